// File: interval_timer_defs.svh
`ifndef INTERVAL_TIMER_DEFS_SVH
`define INTERVAL_TIMER_DEFS_SVH
// register indices on the device port
`define IDX_MODE          1'b0
`define IDX_COUNT         1'b1
// mode register fields
`define MODE_RESTART_BIT  3
`define MODE_RESET        4'h0
// tap divider: divide-by 4096 tap sits at bit 11 of the prescaler
`define PRESCALE_W        12
`define TAP_BIT_4096      11
`define TAP_BIT_512       8
`define TAP_BIT_128       6
`define TAP_BIT_32        4
// reset wait runs on the divide-by 512 tap: 256 periods, 2^17 main clocks
`define RESET_WAIT_SEL    3'b001
// host register map
`define HOST_ADDR_MODE    4'h0
`define HOST_ADDR_COUNT   4'h1
`define HOST_ADDR_STATUS  4'h2
`define HOST_ADDR_MASK    4'h3
`define HOST_ADDR_CMD     4'h4
`define HOST_ADDR_STOP    4'h5
// status bits: 0 overflow seen, 1 wait released
`define ST_OVF            0
`define ST_WAKE           1
`endif

// File: interval_timer_pkg.sv
`default_nettype none
package interval_timer_pkg;
   typedef enum logic [2:0]
   {
      ST_RUN  = 3'b001,
      ST_STOP = 3'b010,
      ST_WAIT = 3'b100
   } standby_state_t;
   typedef logic [3:0] mode_t;
   typedef logic [7:0] count_t;
endpackage
`default_nettype wire

// File: interval_timer_if.sv
`default_nettype none
interface interval_timer_if;
   logic       reg_sel;
   logic [3:0] wdata;
   logic       wr_nibble;
   logic       set_restart;
   logic       rd;
   logic [7:0] rdata;
   logic       irq_clr;
   logic       irq_flag;
   logic       stop_req;
   logic       release_req;
   logic       cpu_halt;
   modport device
   (
      input  reg_sel, wdata, wr_nibble, set_restart, rd, irq_clr,
      input  stop_req, release_req,
      output rdata, irq_flag, cpu_halt
   );
   modport controller
   (
      output reg_sel, wdata, wr_nibble, set_restart, rd, irq_clr,
      output stop_req, release_req,
      input  rdata, irq_flag, cpu_halt
   );
endinterface
`default_nettype wire

// File: tap_select.sv
`default_nettype none
`include "interval_timer_defs.svh"
module tap_select
   import interval_timer_pkg::*;
(
   // clock and reset
   input  wire logic                   clk_i,
   input  wire logic                   rstn_i,
   // selection
   input  wire logic [2:0]             sel_i,
   // one-cycle pulse per period of the chosen tap
   output logic                        tick_o
);
   logic [`PRESCALE_W-1:0] prescale;
   logic [`PRESCALE_W-1:0] next_prescale;
   logic [`PRESCALE_W-1:0] rising;
   logic                   next_tick;

   assign next_prescale = prescale + 12'h001;
   assign rising        = next_prescale & ~prescale;

   // free-running divider; never stops
   always_ff @(posedge clk_i or negedge rstn_i)
      if (!rstn_i)
         prescale <= 12'h000;
      else
         prescale <= next_prescale;

   always_comb
   begin
      case (sel_i)
         3'b000:                 next_tick = rising[`TAP_BIT_4096];
         3'b001, 3'b010, 3'b011: next_tick = rising[`TAP_BIT_512];
         3'b100, 3'b101, 3'b110: next_tick = rising[`TAP_BIT_128];
         default:                next_tick = rising[`TAP_BIT_32];
      endcase
   end

   always_ff @(posedge clk_i or negedge rstn_i)
      if (!rstn_i)
         tick_o <= 1'b0;
      else
         tick_o <= next_tick;
endmodule
`default_nettype wire

// File: interval_timer_device.sv
`default_nettype none
`include "interval_timer_defs.svh"
// Contract
// - counter always counts selected tap, unstoppable
// - rollover from maximum sets interrupt flag
// - mode picks one of four divider taps
// - whole-nibble write, or restart bit alone
// - restart write clears counter and flag
// - reset clears mode, longest interval
// - 1111B selects fastest tap
// - count readable as byte, never loaded
// - software reads count twice, compares
// - software restarts periodically for watchdog use
// - after stop release, halt until overflow
// - reset wait fixed, mode independent
// - stop release wait uses mode interval
// - reset wait equals 2^17 main clocks
module interval_timer_device
   import interval_timer_pkg::*;
(
   // clock and reset
   input  wire logic      clk_i,
   input  wire logic      rstn_i,
   // link
   interval_timer_if.device lnk,
   // raw overflow pulse for the user side
   output logic           overflow_o
);
   mode_t          mode;
   count_t         counter;
   logic           tick;
   logic           ovf;
   logic           restart;
   logic           reset_wait;
   standby_state_t state;
   logic [2:0]     tap_sel;
   logic           clear_cnt;

   // restart may come from a nibble write or the single-bit set
   assign restart = (lnk.wr_nibble && lnk.reg_sel == `IDX_MODE
                     && lnk.wdata[`MODE_RESTART_BIT])
                    || lnk.set_restart;
   // a stop release restarts the count so the wait is one full interval
   assign clear_cnt = restart
                      || (state == ST_STOP && lnk.release_req);
   // during the reset wait a fixed tap is forced, whatever the mode says
   assign tap_sel = reset_wait ? `RESET_WAIT_SEL : mode[2:0];
   // a clear in the same cycle wins: no rollover really happens then
   assign ovf     = tick && counter == 8'hFF && !clear_cnt;

   tap_select u_tap
   (
      .clk_i  (clk_i),
      .rstn_i (rstn_i),
      .sel_i  (tap_sel),
      .tick_o (tick)
   );

   always_ff @(posedge clk_i or negedge rstn_i)
      if (!rstn_i)
         mode <= `MODE_RESET;
      else if (lnk.wr_nibble && lnk.reg_sel == `IDX_MODE)
         mode <= {1'b0, lnk.wdata[2:0]};
      else
         mode <= {1'b0, mode[2:0]};

   // writes never load; restart and stop release are the only clears
   always_ff @(posedge clk_i or negedge rstn_i)
      if (!rstn_i)
         counter <= 8'h00;
      else if (clear_cnt)
         counter <= 8'h00;
      else if (tick)
         counter <= counter + 8'h01;

   // restart clears the flag; overflow in the same cycle is lost since
   // the counter is cleared too and no rollover really happened
   always_ff @(posedge clk_i or negedge rstn_i)
      if (!rstn_i)
         lnk.irq_flag <= 1'b0;
      else if (restart)
         lnk.irq_flag <= 1'b0;
      else if (ovf)
         lnk.irq_flag <= 1'b1;
      else if (lnk.irq_clr)
         lnk.irq_flag <= 1'b0;

   always_ff @(posedge clk_i or negedge rstn_i)
      if (!rstn_i)
         lnk.rdata <= 8'h00;
      else if (lnk.rd)
         lnk.rdata <= (lnk.reg_sel == `IDX_COUNT) ? counter
                      : {4'h0, mode};

   always_ff @(posedge clk_i or negedge rstn_i)
      if (!rstn_i)
         overflow_o <= 1'b0;
      else
         overflow_o <= ovf;

   // reset wait: cpu halted from reset until first overflow
   always_ff @(posedge clk_i or negedge rstn_i)
      if (!rstn_i)
         reset_wait <= 1'b1;
      else if (ovf)
         reset_wait <= 1'b0;

   always_ff @(posedge clk_i or negedge rstn_i)
      if (!rstn_i)
         state <= ST_RUN;
      else
         case (state)
            ST_RUN:
               if (lnk.stop_req)
                  state <= ST_STOP;
            ST_STOP:
               if (lnk.release_req)
                  state <= ST_WAIT;
            ST_WAIT:
               if (ovf)
                  state <= ST_RUN;
            default:
               state <= ST_RUN;
         endcase

   always_ff @(posedge clk_i or negedge rstn_i)
      if (!rstn_i)
         lnk.cpu_halt <= 1'b1;
      else
         lnk.cpu_halt <= (reset_wait && !ovf)
                         || state == ST_STOP
                         || (state == ST_WAIT && !ovf);
endmodule
`default_nettype wire

// File: interval_timer_ctrl.sv
// Our own choices: the plain strobed port and the register offsets.
`default_nettype none
`include "interval_timer_defs.svh"
module interval_timer_ctrl
   import interval_timer_pkg::*;
(
   // clock and reset
   input  wire logic       clk_i,
   input  wire logic       rstn_i,
   // software port
   input  wire logic [3:0] addr_i,
   input  wire logic [7:0] wdata_i,
   input  wire logic       wr_i,
   input  wire logic       rd_i,
   output logic [7:0]      rdata_o,
   output logic            irq_o,
   // link
   interval_timer_if.controller lnk
);
   logic [1:0] status;
   logic [1:0] mask;
   logic       rd_count;
   logic       rd_local;
   logic [7:0] local_data;
   logic       halt_q;

   // commands pass straight through as one-cycle strobes
   always_ff @(posedge clk_i or negedge rstn_i)
      if (!rstn_i)
      begin
         lnk.reg_sel     <= 1'b0;
         lnk.wdata       <= 4'h0;
         lnk.wr_nibble   <= 1'b0;
         lnk.set_restart <= 1'b0;
         lnk.rd          <= 1'b0;
         lnk.irq_clr     <= 1'b0;
         lnk.stop_req    <= 1'b0;
         lnk.release_req <= 1'b0;
      end
      else
      begin
         lnk.reg_sel     <= (addr_i == `HOST_ADDR_COUNT);
         lnk.wdata       <= wdata_i[3:0];
         lnk.wr_nibble   <= wr_i && addr_i == `HOST_ADDR_MODE;
         // cmd bit 0: restart (watchdog kick), bit 1: clear flag
         lnk.set_restart <= wr_i && addr_i == `HOST_ADDR_CMD
                            && wdata_i[0];
         lnk.irq_clr     <= wr_i && addr_i == `HOST_ADDR_CMD
                            && wdata_i[1];
         lnk.rd          <= rd_i && (addr_i == `HOST_ADDR_COUNT
                                     || addr_i == `HOST_ADDR_MODE);
         // stop reg: bit 0 enters stop, bit 1 releases it
         lnk.stop_req    <= wr_i && addr_i == `HOST_ADDR_STOP
                            && wdata_i[0];
         lnk.release_req <= wr_i && addr_i == `HOST_ADDR_STOP
                            && wdata_i[1];
      end

   // device answers one cycle after lnk.rd, so the count path is three cycles;
   // local registers take one stage less and answer after two cycles
   always_ff @(posedge clk_i or negedge rstn_i)
      if (!rstn_i)
      begin
         rd_count   <= 1'b0;
         rd_local   <= 1'b0;
         local_data <= 8'h00;
      end
      else
      begin
         rd_count   <= lnk.rd;
         rd_local   <= rd_i && (addr_i == `HOST_ADDR_STATUS
                                || addr_i == `HOST_ADDR_MASK);
         local_data <= (addr_i == `HOST_ADDR_STATUS) ? {6'h00, status}
                       : {6'h00, mask};
      end

   always_ff @(posedge clk_i or negedge rstn_i)
      if (!rstn_i)
         rdata_o <= 8'h00;
      else if (rd_count)
         rdata_o <= lnk.rdata;
      else if (rd_local)
         rdata_o <= local_data;
      else
         rdata_o <= 8'h00;

   always_ff @(posedge clk_i or negedge rstn_i)
      if (!rstn_i)
         halt_q <= 1'b1;
      else
         halt_q <= lnk.cpu_halt;

   // sticky status, write one to clear; a set wins over the clear, and the overflow bit stays set as long as irq_flag is high
   always_ff @(posedge clk_i or negedge rstn_i)
      if (!rstn_i)
         status <= 2'b00;
      else
      begin
         status[`ST_OVF] <= lnk.irq_flag
            || (status[`ST_OVF] && !(wr_i && addr_i == `HOST_ADDR_STATUS
                                     && wdata_i[`ST_OVF]));
         status[`ST_WAKE] <= (halt_q && !lnk.cpu_halt)
            || (status[`ST_WAKE] && !(wr_i && addr_i == `HOST_ADDR_STATUS
                                      && wdata_i[`ST_WAKE]));
      end

   always_ff @(posedge clk_i or negedge rstn_i)
      if (!rstn_i)
         mask <= 2'b00;
      else if (wr_i && addr_i == `HOST_ADDR_MASK)
         mask <= wdata_i[1:0];

   always_ff @(posedge clk_i or negedge rstn_i)
      if (!rstn_i)
         irq_o <= 1'b0;
      else
         irq_o <= |(status & mask);
endmodule
`default_nettype wire

// File: interval_timer_properties.sv
`default_nettype none
module interval_timer_properties
(
   // clock and reset
   input  wire logic       clk_i,
   input  wire logic       rstn_i,
   // link signals
   input  wire logic       reg_sel,
   input  wire logic [3:0] wdata,
   input  wire logic       wr_nibble,
   input  wire logic       set_restart,
   input  wire logic       rd,
   input  wire logic [7:0] rdata,
   input  wire logic       irq_clr,
   input  wire logic       irq_flag,
   input  wire logic       cpu_halt,
   input  wire logic       stop_req,
   input  wire logic       release_req,
   // registered overflow pulse of the device
   input  wire logic       overflow_i
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [20:0] up_cnt;
   logic        nib_restart;
   assign nib_restart = wr_nibble && !reg_sel && wdata[3];
   // saturating age since reset; margin below the exact wait length
   always_ff @(posedge clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
         up_cnt <= 21'h00_0000;
      else if (!up_cnt[20])
         up_cnt <= up_cnt + 21'h00_0001;
   end
   default clocking @(posedge clk_i); endclocking
   default disable iff (!rstn_i);
   bit_restart_a: assert property (set_restart |=> !irq_flag)
      else $error("flag kept after restart bit");
   nib_restart_a: assert property (nib_restart |=> !irq_flag)
      else $error("flag kept after restart nibble");
   mode_bit3_a: assert property (rd && !reg_sel |=> rdata[7:3] == 5'h00)
      else $error("mode read shows restart bit");
   mode_back_a: assert property ((wr_nibble && !reg_sel) ##1 (rd && !reg_sel)
      |=> rdata[2:0] == $past(wdata[2:0], 2))
      else $error("mode readback differs");
   flag_sticky_a: assert property (irq_flag && !irq_clr && !set_restart
      && !nib_restart |=> irq_flag)
      else $error("flag dropped by itself");
   // an overflow in the clearing cycle wins over the clear
   flag_clear_a: assert property (irq_clr |=> !irq_flag || overflow_i)
      else $error("flag not cleared");
   reset_halt_a: assert property ($rose(rstn_i) |-> cpu_halt)
      else $error("cpu not halted after reset");
   wait_hold_a: assert property (up_cnt < 21'h01_FE00 |-> cpu_halt)
      else $error("reset wait ended early");
   stop_halt_a: assert property (stop_req |-> ##2 cpu_halt)
      else $error("cpu not halted in stop");
   wake_hold_a: assert property (stop_req ##1 release_req |=> cpu_halt)
      else $error("cpu released before wait");
   cover property (set_restart);
   cover property ($rose(irq_flag));
   cover property ((wr_nibble && !reg_sel) ##1 (rd && !reg_sel));
   cover property (stop_req ##1 release_req);
endmodule
`default_nettype wire

// File: interval_timer_tb_top.sv
`default_nettype none
`include "interval_timer_defs.svh"
module interval_timer_tb_top
   import interval_timer_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic       clk_i   = 1'b0;
   logic       rstn_i  = 1'b0;
   logic [3:0] addr_i  = 4'h0;
   logic [7:0] wdata_i = 8'h00;
   logic       wr_i    = 1'b0;
   logic       rd_i    = 1'b0;
   logic [7:0] rdata_o;
   logic       irq_o;
   logic       overflow_o;
   count_t     got;
   int         failures = 0;
   int         n_checks = 0;
   always #20 clk_i = ~clk_i;
   interval_timer_if interval_timer_if_inst ();
   interval_timer_device interval_timer_device_inst (.clk_i(clk_i),
      .rstn_i(rstn_i), .lnk(interval_timer_if_inst), .overflow_o(overflow_o));
   interval_timer_ctrl interval_timer_ctrl_inst (.clk_i(clk_i),
      .rstn_i(rstn_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
      .rd_i(rd_i), .rdata_o(rdata_o), .irq_o(irq_o),
      .lnk(interval_timer_if_inst));
   interval_timer_properties interval_timer_properties_inst (.clk_i(clk_i),
      .rstn_i(rstn_i), .reg_sel(interval_timer_if_inst.reg_sel),
      .wdata(interval_timer_if_inst.wdata),
      .wr_nibble(interval_timer_if_inst.wr_nibble),
      .set_restart(interval_timer_if_inst.set_restart),
      .rd(interval_timer_if_inst.rd), .rdata(interval_timer_if_inst.rdata),
      .irq_clr(interval_timer_if_inst.irq_clr),
      .irq_flag(interval_timer_if_inst.irq_flag),
      .cpu_halt(interval_timer_if_inst.cpu_halt),
      .stop_req(interval_timer_if_inst.stop_req),
      .release_req(interval_timer_if_inst.release_req),
      .overflow_i(overflow_o));
   // the write strobe is left up; the next rd or idle drops it
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      addr_i <= a;
      wdata_i <= d;
      rd_i <= 1'b0;
      wr_i <= 1'b1;
      @(posedge clk_i);
   endtask
   task automatic rd(input logic [3:0] a, input int lat, output count_t q);
      addr_i <= a;
      wr_i <= 1'b0;
      rd_i <= 1'b1;
      @(posedge clk_i);
      rd_i <= 1'b0;
      repeat (lat - 1) @(posedge clk_i);
      #1 q = rdata_o;
   endtask
   task automatic idle(input int n);
      wr_i <= 1'b0;
      rd_i <= 1'b0;
      repeat (n) @(posedge clk_i);
   endtask
   task automatic chk(input count_t g, input count_t lo, input count_t hi);
      n_checks++;
      if ((g >= lo && g <= hi) !== 1'b1)
      begin
         failures++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, g, lo);
      end
   endtask
   task automatic complete_run();
      $display("checks=%0d failures=%0d", n_checks, failures);
      if (failures == 0 && n_checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   initial
   begin
      // the fixed reset wait alone takes 2^17 clocks
      #8000000;
      failures++;
      complete_run();
   end
   initial
   begin
      int d;
      int polls;
      count_t first;
      repeat (5) @(posedge clk_i);
      rstn_i <= 1'b1;
      @(posedge clk_i);
      rd(`HOST_ADDR_MODE, 3, got);
      chk(got, 8'h00, 8'h00);
      wr(`HOST_ADDR_MODE, 8'h0F);
      rd(`HOST_ADDR_MODE, 3, got);
      chk(got, 8'h07, 8'h07);
      wr(`HOST_ADDR_COUNT, 8'hA5);
      rd(`HOST_ADDR_COUNT, 3, got);
      chk(got, 8'h00, 8'h01);
      // the cpu stays halted until the reset wait ends; poll its status
      got = 8'h00;
      polls = 0;
      while (got[`ST_WAKE] !== 1'b1 && polls < 140)
      begin
         idle(1000);
         rd(`HOST_ADDR_STATUS, 2, got);
         polls++;
      end
      chk(got, 8'h03, 8'h03);
      chk(8'(polls), 8'h82, 8'h84);
      // two ticks plus margin for the restart and read pipeline
      for (int m = 0; m < 8; m++)
      begin
         d = (m == 0) ? 4096 : (m < 4) ? 512 : (m < 7) ? 128 : 32;
         wr(`HOST_ADDR_MODE, 8'(m) | 8'h08);
         idle(2 * d + 4);
         rd(`HOST_ADDR_COUNT, 3, got);
         chk(got, 8'h02, 8'h03);
      end
      rd(`HOST_ADDR_COUNT, 3, first);
      rd(`HOST_ADDR_COUNT, 3, got);
      chk(got, first, first + 8'h01);
      wr(`HOST_ADDR_MASK, 8'h01);
      wr(`HOST_ADDR_CMD, 8'h03);
      wr(`HOST_ADDR_STATUS, 8'h03);
      idle(4000);
      rd(`HOST_ADDR_STATUS, 2, got);
      chk(got, 8'h00, 8'h00);
      chk({7'h00, irq_o}, 8'h00, 8'h00);
      idle(4300);
      rd(`HOST_ADDR_STATUS, 2, got);
      chk(got, 8'h01, 8'h01);
      chk({7'h00, irq_o}, 8'h01, 8'h01);
      wr(`HOST_ADDR_CMD, 8'h02);
      wr(`HOST_ADDR_MASK, 8'h00);
      idle(3);
      chk({7'h00, irq_o}, 8'h00, 8'h00);
      wr(`HOST_ADDR_STATUS, 8'h01);
      rd(`HOST_ADDR_STATUS, 2, got);
      chk(got, 8'h00, 8'h00);
      wr(`HOST_ADDR_STOP, 8'h01);
      wr(`HOST_ADDR_STOP, 8'h02);
      idle(4000);
      rd(`HOST_ADDR_STATUS, 2, got);
      chk(got, 8'h00, 8'h00);
      idle(4300);
      rd(`HOST_ADDR_STATUS, 2, got);
      chk(got, 8'h03, 8'h03);
      complete_run();
   end
endmodule
`default_nettype wire
